//--- hdl/asbpf_pkg.sv
package asbpf_pkg;
   // Geometry of the memory port
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int DEPTH  = 8192;
   // Clock period
   localparam int CLK_PERIOD_NS = 10;
   // Timing figures in ns (faster speed grade)
   localparam int T_READ_CYCLE_NS = 100;
   localparam int T_ADDR_ACCESS_NS = 100;
   localparam int T_WRITE_PULSE_NS = 80;
   localparam int T_ADDR_SETUP_NS = 0;
   localparam int T_DATA_SETUP_NS = 50;
   localparam int T_DATA_HOLD_NS = 5;
   localparam int T_WRITE_RECOVERY_NS = 10;
   localparam int T_OUT_FLOAT_NS = 50;
   // Recovery delay after supply return, in us
   localparam int T_RECOVERY_US = 1;
   // Cycle counts, least times rounded up, access one cycle more, hold and recovery at least one cycle
   localparam int CYC_ACCESS = (T_ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int CYC_WRITE_PULSE = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_DATA_SETUP = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_HOLD0 = (T_DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_HOLD = (CYC_HOLD0 < 1) ? 1 : CYC_HOLD0;
   localparam int CYC_RECOVERY0 = (T_WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_RECOVERY = (CYC_RECOVERY0 < 1) ? 1 : CYC_RECOVERY0;
   localparam int CYC_FLOAT = (T_OUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CYC_SUPPLY_REC = T_RECOVERY_US * 1000 / CLK_PERIOD_NS;
   // Host sequencer states
   typedef enum logic [3:0] {
      ASB_IDLE,
      ASB_RD_ADDR,
      ASB_RD_WAIT,
      ASB_RD_DONE,
      ASB_WR_PULSE,
      ASB_WR_HOLD,
      ASB_RECOVER,
      ASB_PWR_DOWN
   } asbpf_state_e;
endpackage : asbpf_pkg

//--- hdl/asbpf_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter: load a count, hold expired from one down to zero
module asbpf_timer
   import asbpf_pkg::*;
#(
   parameter int WIDTH = 12
)(
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             enable,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadValue,
   output logic                  expired
);
   logic [WIDTH-1:0] count_reg;

   // ------------------------------
   // Counter
   // ------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
         count_reg <= loadValue; // Full delay after reset, as after return
      else if (enable)
      begin
         if (load)
            count_reg <= loadValue;
         else if (count_reg != '0)
            count_reg <= count_reg - WIDTH'(1);
      end
   end

   // Expired while the count is at one or zero and no load is applied
   assign expired = (count_reg <= WIDTH'(1)) && !load;
endmodule : asbpf_timer
`default_nettype wire

//--- hdl/asbpf_host.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Host holds address stable through write
// - Host gives data setup and hold
// - Host waits recovery before next access
// - Host keeps output gate off writing
// - Host keeps deselected during power up
module asbpf_host
   import asbpf_pkg::*;
#(
   parameter int SUPPLY_REC_CYCLES = CYC_SUPPLY_REC
)(
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              clockEnable,
   // User command side
   input  wire logic              reqValid,
   output logic                   reqReady,
   input  wire logic              reqWrite,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqWData,
   output logic                   rspValid,
   output logic [DATA_W-1:0]      rspRData,
   output logic                   powerFailed,
   // Memory pins
   output logic [ADDR_W-1:0]      addrPins,
   output logic                   selectLowActive_n,
   output logic                   selectHighActive,
   output logic                   outputGate_n,
   output logic                   writeStrobe_n,
   input  wire logic [DATA_W-1:0] dataPinsIn,
   output logic [DATA_W-1:0]      dataPinsOut,
   output logic                   dataPinsOe,
   input  wire logic              powerFailInt_n
);
   localparam int TW = 12;

   asbpf_state_e     state_reg;
   logic [TW-1:0]    wait_reg;
   logic [DATA_W-1:0] dataSync1_reg;
   logic [DATA_W-1:0] dataSync2_reg;
   logic             intSync1_reg;
   logic             intSync2_reg;
   logic             recLoad;
   logic             recDone;
   logic [4:0]       readAge_reg;

   // ------------------------------
   // Pin synchronisers
   // ------------------------------
   // Two stages; first stage feeds only the second
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         dataSync1_reg <= '0;
         dataSync2_reg <= '0;
         intSync1_reg  <= 1'b1;
         intSync2_reg  <= 1'b1;
      end
      else if (clockEnable)
      begin
         dataSync1_reg <= dataPinsIn;
         dataSync2_reg <= dataSync1_reg;
         intSync1_reg  <= powerFailInt_n; // Low is asserted, open drain
         intSync2_reg  <= intSync1_reg;
      end
   end

   // ------------------------------
   // Supply recovery timer
   // ------------------------------
   // Restart on every low interrupt level so delay runs from return
   assign recLoad = !intSync2_reg;

   asbpf_timer #(
      .WIDTH (TW)
   ) u_asbpf_timer (
      .clock     (clock),
      .reset     (reset),
      .enable    (clockEnable),
      .load      (recLoad),
      .loadValue (TW'(SUPPLY_REC_CYCLES)),
      .expired   (recDone)
   );

   // Fail state seen as abstract pin event
   assign powerFailed = (state_reg == ASB_PWR_DOWN);
   assign reqReady    = (state_reg == ASB_IDLE) && intSync2_reg && recDone;

   // ------------------------------
   // Access sequencer
   // ------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_reg         <= ASB_PWR_DOWN;
         wait_reg          <= '0;
         addrPins          <= '0;
         selectLowActive_n <= 1'b1; // Deselected out of reset
         selectHighActive  <= 1'b0;
         outputGate_n      <= 1'b1;
         writeStrobe_n     <= 1'b1;
         dataPinsOut       <= '0;
         dataPinsOe        <= 1'b0;
         rspValid          <= 1'b0;
         rspRData          <= '0;
      end
      else if (clockEnable)
      begin
         rspValid <= 1'b0;
         if (wait_reg != '0)
            wait_reg <= wait_reg - TW'(1);
         case (state_reg)
            ASB_IDLE:
            begin
               if (!intSync2_reg)
                  state_reg <= ASB_PWR_DOWN;
               else if (reqValid && recDone)
               begin
                  addrPins <= reqAddr; // Address set in the same cycle as selects
                  if (reqWrite)
                  begin
                     // Gate stays off while writing
                     outputGate_n      <= 1'b1;
                     dataPinsOut       <= reqWData;
                     dataPinsOe        <= 1'b1;
                     selectLowActive_n <= 1'b0;
                     selectHighActive  <= 1'b1;
                     writeStrobe_n     <= 1'b0; // Last edge starts write
                     wait_reg <= TW'((CYC_WRITE_PULSE > CYC_DATA_SETUP)
                                     ? CYC_WRITE_PULSE : CYC_DATA_SETUP);
                     state_reg <= ASB_WR_PULSE;
                  end
                  else
                  begin
                     writeStrobe_n     <= 1'b1; // Strobe high is read
                     selectLowActive_n <= 1'b0;
                     selectHighActive  <= 1'b1;
                     outputGate_n      <= 1'b0; // Device drives now
                     dataPinsOe        <= 1'b0;
                     // Wait out access plus sync latency
                     wait_reg  <= TW'(CYC_ACCESS + 2);
                     state_reg <= ASB_RD_WAIT;
                  end
               end
            end
            ASB_RD_WAIT:
            begin
               if (wait_reg <= TW'(1))
               begin
                  rspRData  <= dataSync2_reg;
                  rspValid  <= 1'b1;
                  state_reg <= ASB_RD_DONE;
               end
            end
            ASB_RD_DONE:
            begin
               outputGate_n      <= 1'b1;
               selectLowActive_n <= 1'b1;
               selectHighActive  <= 1'b0;
               wait_reg  <= TW'(CYC_FLOAT);
               state_reg <= ASB_RECOVER; // Let device float before reuse
            end
            ASB_WR_PULSE:
            begin
               if (wait_reg <= TW'(1))
               begin
                  // First release ends write, data latched
                  writeStrobe_n     <= 1'b1;
                  selectLowActive_n <= 1'b1;
                  selectHighActive  <= 1'b0;
                  wait_reg  <= TW'(CYC_HOLD);
                  state_reg <= ASB_WR_HOLD;
               end
            end
            ASB_WR_HOLD:
            begin
               if (wait_reg <= TW'(1))
               begin
                  dataPinsOe <= 1'b0; // Data and address held past end
                  wait_reg   <= TW'(CYC_RECOVERY);
                  state_reg  <= ASB_RECOVER;
               end
            end
            ASB_RECOVER:
            begin
               if (wait_reg <= TW'(1))
                  state_reg <= ASB_IDLE; // Recovery before next access
            end
            ASB_PWR_DOWN:
            begin
               // Keep deselected while supply unsure
               selectLowActive_n <= 1'b1;
               selectHighActive  <= 1'b0;
               outputGate_n      <= 1'b1;
               writeStrobe_n     <= 1'b1;
               dataPinsOe        <= 1'b0;
               if (intSync2_reg && recDone)
                  state_reg <= ASB_IDLE;
            end
            default:
               state_reg <= ASB_PWR_DOWN;
         endcase
      end
   end

   // ------------------------------
   // Checks
   // ------------------------------
   // Enabled cycles with the output gate on; a counter, since the access
   // wait is longer than a repetition may span
   always_ff @(posedge clock)
   begin
      if (reset)
         readAge_reg <= '0;
      else if (clockEnable)
      begin
         if (outputGate_n)
            readAge_reg <= '0;
         else if (readAge_reg != 5'h1f)
            readAge_reg <= readAge_reg + 5'h01;
      end
   end

   sequence writeEnd_s;
      $rose(writeStrobe_n) ##0 selectLowActive_n;
   endsequence

   gate_off_write_a: assert property (@(posedge clock) disable iff (reset)
      !writeStrobe_n |-> outputGate_n)
      else $error("Gate active during write");

   no_fight_a: assert property (@(posedge clock) disable iff (reset)
      dataPinsOe |-> outputGate_n)
      else $error("Host drives with gate on");

   addr_stable_a: assert property (@(posedge clock) disable iff (reset)
      (!writeStrobe_n && clockEnable) |=> $stable(addrPins))
      else $error("Address moved in write");

   data_hold_a: assert property (@(posedge clock) disable iff (reset)
      (writeEnd_s and (clockEnable)) |-> dataPinsOe)
      else $error("Data not held at write end");

   pulse_width_a: assert property (@(posedge clock) disable iff (reset || !clockEnable)
      $fell(writeStrobe_n) |-> !writeStrobe_n [*8])
      else $error("Write pulse too short");

   pwr_deselect_a: assert property (@(posedge clock) disable iff (reset)
      powerFailed |-> (selectLowActive_n && !selectHighActive))
      else $error("Selected while power failed");

   recover_gap_a: assert property (@(posedge clock) disable iff (reset || !clockEnable)
      $rose(writeStrobe_n) |=> selectLowActive_n)
      else $error("No recovery after write");

   read_wait_a: assert property (@(posedge clock) disable iff (reset)
      rspValid |-> (readAge_reg >= 5'(CYC_ACCESS - 1)))
      else $error("Read sampled too early");
endmodule : asbpf_host
`default_nettype wire

//--- bench/asbpf_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Battery-backed byte memory, pin level
// ----------------------------------------
module asbpf_sram_model
   import asbpf_pkg::*;
#(
   parameter int DESEL_CYC = 1000,
   parameter int REC_CYC   = 4
)(
   input  wire logic              clock,
   input  wire logic [ADDR_W-1:0] addrPins,
   input  wire logic              selectLowActive_n,
   input  wire logic              selectHighActive,
   input  wire logic              outputGate_n,
   input  wire logic              writeStrobe_n,
   input  wire logic [DATA_W-1:0] dataPinsOut,
   input  wire logic              dataPinsOe,
   input  wire logic              supplyLow,
   output logic [DATA_W-1:0]      dataPinsIn,
   output logic                   powerFailInt_n,
   output logic                   hostFault = 1'b0
);
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] lastBus  = '0;
   logic [DATA_W-1:0] prevData = '0;
   logic [ADDR_W-1:0] prevAddr = '0;
   logic              protect  = 1'b0;
   logic              wasWrite = 1'b0;
   logic              selOn;
   logic              readOn;
   logic              writeOn;
   int                accCnt, failCnt, recCnt, setupCnt;

   // Decode of the pin states; protection masks the select decode, so every read and write
   assign selOn   = !selectLowActive_n && selectHighActive && !protect;
   assign writeOn = selOn && !writeStrobe_n;
   assign readOn  = selOn && writeStrobe_n && !outputGate_n;
   // Open-drain line seen with its pull-up
   assign powerFailInt_n = supplyLow ? 1'b0 : 1'b1;

   // Bus level; a floating line shows a changing pattern, not the old byte
   always_comb
      if (dataPinsOe)
         dataPinsIn = dataPinsOut;
      else if (readOn && accCnt >= T_ADDR_ACCESS_NS / CLK_PERIOD_NS - 1)
         dataPinsIn = mem[addrPins];
      else
         dataPinsIn = ~lastBus;

   // Byte stored at the first releasing edge; only that byte is at risk
   always @(negedge writeOn)
      mem[addrPins] = dataPinsIn;

   // Access timing, power-fail timers and checks of the host's side
   always @(posedge clock)
   begin
      accCnt   <= (addrPins != prevAddr || !readOn) ? 0 : accCnt + 1;
      setupCnt <= (writeOn && dataPinsIn == prevData) ? setupCnt + 1 : 0;
      prevAddr <= addrPins;
      prevData <= dataPinsIn;
      lastBus  <= dataPinsIn;
      wasWrite <= writeOn;
      failCnt  <= supplyLow ? failCnt + 1 : 0;
      recCnt   <= (supplyLow || !protect) ? 0 : recCnt + 1;
      if (supplyLow && failCnt >= DESEL_CYC)
         protect <= 1'b1;
      else if (!supplyLow && recCnt >= REC_CYC)
         protect <= 1'b0;
      if (writeOn && wasWrite && addrPins != prevAddr)
         hostFault <= 1'b1;
      if (wasWrite && !writeOn && setupCnt < CYC_DATA_SETUP - 1)
         hostFault <= 1'b1;
      if (writeOn && !outputGate_n)
         hostFault <= 1'b1;
   end
endmodule : asbpf_sram_model
`default_nettype wire

//--- bench/test_async_sram_bus_power_fail.sv
`timescale 1ns/1ps
`default_nettype none
module test_async_sram_bus_power_fail
   import asbpf_pkg::*;
;
   logic              clock = 1'b0;
   logic              reset = 1'b1;
   logic              clockEnable = 1'b1;
   logic              reqValid = 1'b0;
   logic              reqWrite = 1'b0;
   logic              supplyLow = 1'b0;
   logic [ADDR_W-1:0] reqAddr = '0;
   logic [ADDR_W-1:0] addrPins;
   logic [DATA_W-1:0] reqWData = '0;
   logic [DATA_W-1:0] rspRData, dataPinsIn, dataPinsOut;
   logic              reqReady, rspValid, powerFailed, selectLowActive_n;
   logic              selectHighActive, outputGate_n, writeStrobe_n;
   logic              dataPinsOe, powerFailInt_n, hostFault;
   int                mismatches = 0;
   int                compares = 0;

   asbpf_host #(.SUPPLY_REC_CYCLES(4)) u_asbpf_host (.clock, .reset, .clockEnable,
      .reqValid, .reqReady, .reqWrite, .reqAddr, .reqWData, .rspValid, .rspRData,
      .powerFailed, .addrPins, .selectLowActive_n, .selectHighActive, .outputGate_n,
      .writeStrobe_n, .dataPinsIn, .dataPinsOut, .dataPinsOe, .powerFailInt_n);
   asbpf_sram_model u_asbpf_sram_model (.clock, .addrPins, .selectLowActive_n,
      .selectHighActive, .outputGate_n, .writeStrobe_n, .dataPinsOut, .dataPinsOe,
      .supplyLow, .dataPinsIn, .powerFailInt_n, .hostFault);

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // Free-running clock
   initial
      forever #5 clock = ~clock;

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic finish_test();
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   // Bounded wait; a hang is judged at once
   task automatic wait_ready(output int n);
      n = 0;
      while (reqReady !== 1'b1)
      begin
         @(negedge clock);
         n++;
         if (n > 300)
         begin
            check("reqReady", 1, 0);
            finish_test();
         end
      end
   endtask : wait_ready

   // Request held from a falling edge until the taking rising edge
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(negedge clock);
      wait_ready(n);
      reqValid = 1'b1;
      reqWrite = wr;
      reqAddr = a;
      reqWData = d;
      @(negedge clock);
      reqValid = 1'b0;
   endtask : issue

   task automatic do_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      int n;
      issue(1'b0, a, '0);
      for (n = 0; n < 30 && rspValid !== 1'b1; n++)
         @(negedge clock);
      if (n == 30)
         check("rspValid", 1, 0);
      else
         check("rspRData", exp, rspRData);
   endtask : do_read

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic sc_reset();
      int n;
      repeat (12) @(negedge clock);
      check("selectLowActive_n", 1, selectLowActive_n);
      check("powerFailed", 1, powerFailed);
      reset = 1'b0;
      wait_ready(n);
      check("recoveryWait", 1, n >= 4);
   endtask : sc_reset

   // Corner addresses, neighbours, then a stall with the clock enable low
   task automatic sc_write_read();
      logic [ADDR_W-1:0] a [4] = '{13'h0000, 13'h1fff, 13'h0001, 13'h1000};
      logic [DATA_W-1:0] d [4] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3};
      for (int i = 0; i < 4; i++)
         issue(1'b1, a[i], d[i]);
      for (int i = 3; i >= 0; i--)
         do_read(a[i], d[i]);
      issue(1'b0, a[1], '0);
      clockEnable = 1'b0;
      repeat (20) @(negedge clock);
      clockEnable = 1'b1;
      for (int k = 0; k < 30 && rspValid !== 1'b1; k++)
         @(negedge clock);
      check("stallRead", d[1], rspRData);
      do_read(a[2], d[2]);
      check("dataPinsOe", 0, dataPinsOe);
   endtask : sc_write_read

   // Supply loss with a request pending, then return and readback
   task automatic sc_power_fail();
      int n;
      int bad;
      wait_ready(n);
      supplyLow = 1'b1;
      for (n = 0; n < 8 && powerFailed !== 1'b1; n++)
         @(negedge clock);
      check("failLatency", 1, n < 5);
      reqValid = 1'b1;
      reqWrite = 1'b1;
      reqAddr = '0;
      reqWData = 8'hff;
      bad = 0;
      repeat (1100)
      begin
         @(negedge clock);
         bad += (selectLowActive_n !== 1'b1 || reqReady !== 1'b0);
      end
      check("accessInFail", 0, bad);
      reqValid = 1'b0;
      supplyLow = 1'b0;
      @(negedge clock);
      wait_ready(n);
      check("recoveryWait", 1, n >= 4);
      do_read(13'h0000, 8'ha5);
      do_read(13'h1fff, 8'h5a);
   endtask : sc_power_fail

   // Main sequence
   initial
   begin
      sc_reset();
      sc_write_read();
      sc_power_fail();
      check("hostFault", 0, hostFault);
      finish_test();
   end
endmodule : test_async_sram_bus_power_fail
`default_nettype wire
